// *** hw/fplg_guard.sv ***
// Flash page lock guard: access checks, key sequence and store control
//
// Function
// - Any zero lock bit locks lock-byte page
// - Debug port cannot touch locked pages
// - Unlocked-page firmware cannot touch locked pages
// - Locked-page firmware reads/writes all but reserved
// - Locked-page firmware erases all but reserved, lock
// - Only debug device erase clears locks
// - Denied firmware access pulses flash-error reset, flag
// - Denied debug requests ignored, no reset
// - No locks: lock page open, firmware erase resets
// - Any lock: lock page for locked firmware only
// - Reserved area denied to every requester
// - Written lock byte cannot be changed
// - New lock byte applies after next reset
// - Firmware modify needs supply monitor and its reset
// - Both enables: move write erases whole page
// - Write enable steers move writes to flash
// - Interrupts held pending during flash write or erase
// - Lock count is complement of last user byte
// - Keys A5 then F1 before each modify
// - Addresses 0x3E00 to 0x3FFF are reserved
//
// Decided for this implementation: the APB slave port.
module fplg_guard (
    input wire logic clk_i,                      // System clock, 250 MHz
    input wire logic rstn_i,                     // Device reset, async
    input wire logic por_rstn_i,                 // Power-on reset, async
    // APB slave
    input wire logic psel_i,                     // Slave select
    input wire logic penable_i,                  // Access phase
    input wire logic pwrite_i,                   // Write direction
    input wire logic [fplg_pkg::APB_AW-1:0] paddr_i,  // Byte address
    input wire logic [31:0] pwdata_i,            // Write data
    output logic [31:0] prdata_o,                // Read data
    output logic pready_o,                       // Always ready
    output logic pslverr_o,                      // Unmapped address
    // Access requests
    input wire logic req_valid_i,                // Request offered
    input wire logic req_debug_i,                // 1: debug port
    input wire fplg_pkg::fplg_op_t req_op_i,     // Requested operation
    input wire logic [fplg_pkg::FA_W-1:0] req_addr_i, // Target address
    input wire logic [7:0] req_data_i,           // Write data
    input wire logic [fplg_pkg::FA_W-1:0] pc_i,  // Firmware program ctr
    output logic req_ready_o,                    // Request taken
    // Flash array side
    input wire logic [7:0] lock_byte_i,          // Stored lock byte
    input wire logic flash_done_i,               // Write/erase finished
    output logic flash_cmd_valid_o,              // Command pulse
    output fplg_pkg::fplg_op_t flash_cmd_o,      // Command kind
    output logic [fplg_pkg::FA_W-1:0] flash_addr_o, // Command address
    output logic [7:0] flash_data_o,             // Command data
    // System side
    output logic xram_wr_o,                      // Move write to RAM
    output logic dbg_ignored_o,                  // Debug request dropped
    output logic flash_error_reset_o,            // Device reset pulse
    output logic irq_hold_o                      // Hold interrupts
);
    import fplg_pkg::*;

    // ==========================================================
    // Reset synchronisers
    // ==========================================================
    logic rst_n;                // Device reset, synchronous release
    logic por_n;                // Power-on reset, synchronous release

    fplg_rst_sync u_rst_sync (
        .clk_i(clk_i),
        .arstn_i(rstn_i),
        .rstn_o(rst_n)
    );

    fplg_rst_sync u_por_sync (
        .clk_i(clk_i),
        .arstn_i(por_rstn_i),
        .rstn_o(por_n)
    );

    // ==========================================================
    // State declarations
    // ==========================================================
    logic [1:0] ctrl_q, ctrl_d;                 // Erase and write enable
    fplg_key_t key_q, key_d;                    // Key sequence state
    logic [7:0] lock_q, lock_d;                 // Lock byte seen at reset
    logic lock_vld_q, lock_vld_d;               // Lock byte captured
    logic busy_q, busy_d;                       // Write/erase running
    logic mon_en_q, mon_en_d;                   // Supply monitor enabled
    logic mon_rst_q, mon_rst_d;                 // Monitor is reset src
    logic por_flag_q, por_flag_d;               // Power-on flag
    logic ferr_q, ferr_d;                       // Flash error flag
    logic [31:0] prdata_d;                      // Next read data
    logic cmd_vld_d, xram_d, ign_d, ferr_rst_d; // Next pulses
    fplg_op_t cmd_d;                            // Next command kind
    logic [FA_W-1:0] addr_d;                    // Next command address
    logic [7:0] data_d;                         // Next command data

    // ==========================================================
    // APB decode
    // ==========================================================
    logic acc;                  // Access phase, completes this edge
    logic wr_ctrl, wr_key, wr_rst;  // Register write strobes
    logic mapped;               // Address hits a register

    assign acc = psel_i && penable_i;
    assign mapped = (paddr_i == CTRL_ADDR) || (paddr_i == KEY_ADDR) ||
                    (paddr_i == SRC_ADDR) || (paddr_i == STATUS_ADDR);
    assign wr_ctrl = acc && pwrite_i && (paddr_i == CTRL_ADDR);
    assign wr_key = acc && pwrite_i && (paddr_i == KEY_ADDR);
    assign wr_rst = acc && pwrite_i && (paddr_i == SRC_ADDR);
    // Zero wait states; error answer only on unmapped addresses
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !mapped;

    // ==========================================================
    // Page classification
    // ==========================================================
    logic [7:0] lock_cnt;       // Number of locked pages from page 0
    logic any_lock;             // At least one page locked
    logic [PAGE_W-1:0] tgt_pg, pc_pg, lock_pg;
    logic tgt_locked, pc_locked, tgt_rsvd, tgt_lock_pg;

    assign lock_cnt = ~lock_q;
    assign any_lock = (lock_q != LOCK_ERASED);
    assign tgt_pg = req_addr_i[FA_W-1:PAGE_SHIFT];
    assign pc_pg = pc_i[FA_W-1:PAGE_SHIFT];
    assign lock_pg = LOCK_BYTE_ADDR[FA_W-1:PAGE_SHIFT];
    assign tgt_lock_pg = (tgt_pg == lock_pg);
    // Lock page joins the locked set whenever any bit is zero
    assign tgt_locked = ({3'h0, tgt_pg} < lock_cnt) ||
                        (any_lock && tgt_lock_pg);
    assign pc_locked = ({3'h0, pc_pg} < lock_cnt) ||
                       (any_lock && (pc_pg == lock_pg));
    assign tgt_rsvd = (req_addr_i >= RESERVED_BASE);

    // ==========================================================
    // Access decision
    // ==========================================================
    logic take;                 // Request accepted this cycle
    logic deny;                 // Operation not permitted
    logic modify;               // Firmware write or erase to flash
    logic is_erase;             // Effective operation is an erase
    logic lock_rewrite;         // Write to an already-written lock byte

    // Requests wait until the lock byte is known and flash is idle
    assign req_ready_o = lock_vld_q && !busy_q;
    assign take = req_valid_i && req_ready_o;
    assign lock_rewrite = (req_addr_i == LOCK_BYTE_ADDR) &&
                          (lock_byte_i != LOCK_ERASED);

    // Firmware move write becomes erase when both enables are set
    assign is_erase = req_debug_i ? (req_op_i == FPLG_OP_ERASE) :
                      ((req_op_i == FPLG_OP_WRITE) &&
                       ctrl_q[ERASE_EN_BIT]);
    assign modify = !req_debug_i && (req_op_i == FPLG_OP_WRITE) &&
                    ctrl_q[WRITE_EN_BIT];

    // Deny table, common to both requesters
    always_comb begin
        deny = 1'b0;
        if (req_debug_i) begin
            if (req_op_i == FPLG_OP_DEV_ERASE) begin
                deny = 1'b0;
            end else if (tgt_rsvd) begin
                deny = 1'b1;
            end else if (tgt_locked) begin
                deny = 1'b1;
            end else if (req_op_i == FPLG_OP_WRITE && lock_rewrite) begin
                deny = 1'b1;
            end
        end else if (req_op_i == FPLG_OP_READ) begin
            // Reads from locked code reach every non-reserved page
            deny = tgt_rsvd || (tgt_locked && !pc_locked);
        end else if (modify) begin
            if (tgt_rsvd) begin
                deny = 1'b1;
            end else if (!(mon_en_q && mon_rst_q)) begin
                deny = 1'b1;
            end else if (is_erase && tgt_lock_pg) begin
                deny = 1'b1;
            end else if (tgt_locked && !pc_locked) begin
                deny = 1'b1;
            end else if (!is_erase && lock_rewrite) begin
                deny = 1'b1;
            end
        end else if (req_op_i != FPLG_OP_WRITE) begin
            // Firmware has no erase or device-erase path of its own
            deny = 1'b1;
        end
    end

    // ==========================================================
    // Request, command and flag next state
    // ==========================================================
    always_comb begin
        cmd_vld_d = 1'b0;
        cmd_d = FPLG_OP_READ;
        addr_d = flash_addr_o;
        data_d = flash_data_o;
        xram_d = 1'b0;
        ign_d = 1'b0;
        ferr_rst_d = 1'b0;
        busy_d = busy_q && !flash_done_i;
        key_d = key_q;
        // Key register writes walk the two-code sequence
        if (wr_key && key_q != FPLG_KEY_DEAD) begin
            unique case (key_q)
                FPLG_KEY_IDLE: begin
                    key_d = (pwdata_i[7:0] == KEY_CODE_FIRST) ?
                            FPLG_KEY_HALF : FPLG_KEY_DEAD;
                end
                FPLG_KEY_HALF: begin
                    key_d = (pwdata_i[7:0] == KEY_CODE_SECOND) ?
                            FPLG_KEY_ARMED : FPLG_KEY_DEAD;
                end
                FPLG_KEY_ARMED: begin
                    key_d = FPLG_KEY_DEAD;
                end
                FPLG_KEY_DEAD: begin
                    key_d = FPLG_KEY_DEAD;
                end
            endcase
        end
        if (take) begin
            if (req_debug_i && deny) begin
                ign_d = 1'b1;
            end else if (deny) begin
                ferr_rst_d = 1'b1;
            end else if (!req_debug_i && req_op_i == FPLG_OP_WRITE &&
                         !modify) begin
                xram_d = 1'b1;
            end else if (modify && key_q != FPLG_KEY_ARMED) begin
                // Modify without both codes: disabled until reset
                key_d = FPLG_KEY_DEAD;
            end else begin
                cmd_vld_d = 1'b1;
                addr_d = req_addr_i;
                data_d = req_data_i;
                if (req_debug_i) begin
                    cmd_d = req_op_i;
                end else if (req_op_i == FPLG_OP_READ) begin
                    cmd_d = FPLG_OP_READ;
                end else begin
                    cmd_d = is_erase ? FPLG_OP_ERASE : FPLG_OP_WRITE;
                end
                if (cmd_d != FPLG_OP_READ) begin
                    busy_d = 1'b1;
                end
                // Each firmware modify consumes the key
                if (modify) begin
                    key_d = FPLG_KEY_IDLE;
                end
            end
        end
    end

    // ==========================================================
    // Register file next state
    // ==========================================================
    always_comb begin
        ctrl_d = wr_ctrl ? pwdata_i[1:0] : ctrl_q;
        mon_en_d = wr_rst ? pwdata_i[MON_EN_BIT] : mon_en_q;
        mon_rst_d = wr_rst ? pwdata_i[MON_RST_BIT] : mon_rst_q;
        // Software may clear the flags; a same-cycle event wins
        por_flag_d = wr_rst ? pwdata_i[POR_FLAG_BIT] : por_flag_q;
        ferr_d = (wr_rst ? pwdata_i[FERR_FLAG_BIT] : ferr_q) ||
                 ferr_rst_d;
        // Lock byte is sampled once after each device reset
        lock_vld_d = 1'b1;
        lock_d = lock_vld_q ? lock_q : lock_byte_i;
        prdata_d = 32'h0000_0000;
        if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                CTRL_ADDR: prdata_d = {30'h0, ctrl_q};
                KEY_ADDR: prdata_d = {30'h0, key_q};
                SRC_ADDR: begin
                    prdata_d[MON_EN_BIT] = mon_en_q;
                    prdata_d[FERR_FLAG_BIT] = ferr_q;
                    prdata_d[POR_FLAG_BIT] = por_flag_q;
                    prdata_d[MON_RST_BIT] = mon_rst_q;
                end
                STATUS_ADDR: prdata_d = {22'h0, busy_q, any_lock, lock_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Registers cleared by device reset
    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            key_q <= FPLG_KEY_IDLE;
            lock_q <= LOCK_ERASED;
            lock_vld_q <= 1'b0;
            busy_q <= 1'b0;
            mon_en_q <= 1'b0;
            mon_rst_q <= 1'b0;
            prdata_o <= 32'h0000_0000;
            flash_cmd_valid_o <= 1'b0;
            flash_cmd_o <= FPLG_OP_READ;
            flash_addr_o <= '0;
            flash_data_o <= 8'h00;
            xram_wr_o <= 1'b0;
            dbg_ignored_o <= 1'b0;
            flash_error_reset_o <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            key_q <= key_d;
            lock_q <= lock_d;
            lock_vld_q <= lock_vld_d;
            busy_q <= busy_d;
            mon_en_q <= mon_en_d;
            mon_rst_q <= mon_rst_d;
            prdata_o <= prdata_d;
            flash_cmd_valid_o <= cmd_vld_d;
            flash_cmd_o <= cmd_d;
            flash_addr_o <= addr_d;
            flash_data_o <= data_d;
            xram_wr_o <= xram_d;
            dbg_ignored_o <= ign_d;
            flash_error_reset_o <= ferr_rst_d;
        end
    end

    // ==========================================================
    // Reset-source flags survive device reset; power-on sets the power-on flag, clears the error flag
    // ==========================================================
    always_ff @(posedge clk_i or negedge por_n) begin
        if (!por_n) begin
            por_flag_q <= 1'b1;
            ferr_q <= 1'b0;
        end else begin
            por_flag_q <= por_flag_d;
            ferr_q <= ferr_d;
        end
    end

    // Interrupt hold follows the running write or erase
    assign irq_hold_o = busy_q;

endmodule : fplg_guard

// *** hw/fplg_rst_sync.sv ***
// Reset release synchroniser: asserts at once, releases after two edges
module fplg_rst_sync (
    input wire logic clk_i,     // System clock
    input wire logic arstn_i,   // Asynchronous reset, active low
    output logic rstn_o         // Synchronised reset, active low
);

    // ==========================================================
    // Two-stage release chain
    // ==========================================================
    logic meta_q;               // First stage, read only by second

    // Constants only under reset; release ripples through two stages
    always_ff @(posedge clk_i or negedge arstn_i) begin
        if (!arstn_i) begin
            meta_q <= 1'b0;
            rstn_o <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            rstn_o <= meta_q;
        end
    end

endmodule : fplg_rst_sync

// *** shared/fplg_pkg.sv ***
// Shared constants and types of the flash page lock guard
package fplg_pkg;

    // ==========================================================
    // Register map (APB byte addresses, one 32-bit word each)
    // ==========================================================
    localparam int APB_AW = 12;                    // APB address width
    localparam logic [APB_AW-1:0] CTRL_IDX = 12'h08F;  // Printed index
    localparam logic [APB_AW-1:0] CTRL_ADDR = {CTRL_IDX[9:0], 2'b00};
    localparam logic [APB_AW-1:0] KEY_ADDR = 12'h240;    // Key register
    localparam logic [APB_AW-1:0] SRC_ADDR = 12'h244;    // Reset sources
    localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h248; // Guard status

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int WRITE_EN_BIT = 0;               // Flash write enable
    localparam int ERASE_EN_BIT = 1;               // Page erase enable
    localparam logic [1:0] CTRL_RESET = 2'h0;      // Both enables clear
    localparam int MON_RST_BIT = 0;                // Monitor as reset src
    localparam int POR_FLAG_BIT = 1;               // Power-on flag
    localparam int FERR_FLAG_BIT = 6;              // Flash error flag
    localparam int MON_EN_BIT = 7;                 // Supply monitor on
    localparam logic [7:0] KEY_CODE_FIRST = 8'hA5; // First key code
    localparam logic [7:0] KEY_CODE_SECOND = 8'hF1; // Second key code

    // ==========================================================
    // Flash geometry
    // ==========================================================
    localparam int FA_W = 14;                      // Flash address width
    localparam int PAGE_SHIFT = 9;                 // 512-byte pages
    localparam int PAGE_W = FA_W - PAGE_SHIFT;     // Page number width
    localparam logic [FA_W-1:0] RESERVED_BASE = 14'h3E00; // To 0x3FFF
    localparam logic [FA_W-1:0] LOCK_BYTE_ADDR = 14'h3DFF; // Last user
    localparam logic [7:0] LOCK_ERASED = 8'hFF;    // Unwritten lock byte

    // ==========================================================
    // Enumerations
    // ==========================================================
    typedef enum logic [1:0] {
        FPLG_OP_READ = 2'h0,       // Byte read
        FPLG_OP_WRITE = 2'h1,      // Byte write (firmware: move write)
        FPLG_OP_ERASE = 2'h2,      // Page erase
        FPLG_OP_DEV_ERASE = 2'h3   // Whole-device erase, debug only
    } fplg_op_t;

    typedef enum logic [1:0] {
        FPLG_KEY_IDLE = 2'b00,     // No code seen
        FPLG_KEY_HALF = 2'b01,     // First code seen
        FPLG_KEY_ARMED = 2'b11,    // Both codes seen
        FPLG_KEY_DEAD = 2'b10      // Wrong order, locked until reset
    } fplg_key_t;

endpackage : fplg_pkg

// *** tb/fplg_flash_model.sv ***
// Flash array stand-in holding the lock byte
module fplg_flash_model #(
    parameter int DONE_DLY = 5 // Cycles from command to done
) (
    input wire logic clk_i, // System clock
    input wire logic cmd_valid_i, // Command pulse
    input wire fplg_pkg::fplg_op_t cmd_i, // Command kind
    input wire logic [fplg_pkg::FA_W-1:0] addr_i, // Address
    input wire logic [7:0] data_i, // Command data
    output logic [7:0] lock_byte_o, // Stored lock byte
    output logic done_o // Modify finished
);
    import fplg_pkg::*;
    int cnt_q = 0; // Cycles left
    logic [7:0] lock_q = LOCK_ERASED; // Blank part
    assign lock_byte_o = lock_q;
    // No reset: the byte survives device reset
    always @(posedge clk_i) begin
        done_o <= (cnt_q == 1);
        if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
        if (cmd_valid_i && cmd_i != FPLG_OP_READ) begin
            cnt_q <= DONE_DLY;
            // Programming only clears bits
            if (cmd_i == FPLG_OP_WRITE && addr_i == LOCK_BYTE_ADDR)
                lock_q <= lock_q & data_i;
            if (cmd_i == FPLG_OP_DEV_ERASE || (cmd_i == FPLG_OP_ERASE
                && addr_i[13:9] == LOCK_BYTE_ADDR[13:9]))
                lock_q <= LOCK_ERASED;
        end
    end
endmodule : fplg_flash_model

// *** tb/fplg_guard_properties.sv ***
// Assertions on the guard's ports
module fplg_guard_properties (
    input wire logic clk_i, // System clock
    input wire logic rstn_i, // Device reset
    input wire logic req_valid_i, // Request offered
    input wire logic req_debug_i, // Debug requester
    input wire fplg_pkg::fplg_op_t req_op_i, // Operation
    input wire logic [fplg_pkg::FA_W-1:0] req_addr_i, // Target
    input wire logic [7:0] req_data_i, // Write data
    input wire logic req_ready_o, // Request taken
    input wire logic flash_cmd_valid_o, // Command pulse
    input wire fplg_pkg::fplg_op_t flash_cmd_o, // Command kind
    input wire logic [fplg_pkg::FA_W-1:0] flash_addr_o, // Address
    input wire logic [7:0] flash_data_o, // Command data
    input wire logic xram_wr_o, // Move write to RAM
    input wire logic dbg_ignored_o, // Debug dropped
    input wire logic flash_error_reset_o, // Reset pulse
    input wire logic irq_hold_o // Hold interrupts
);
    import fplg_pkg::*;
    wire tk = req_valid_i && req_ready_o; // Taken this edge
    wire rsv = req_addr_i >= RESERVED_BASE; // Reserved target
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_dbg_quiet;
        tk && req_debug_i |=> !flash_error_reset_o && !xram_wr_o;
    endproperty
    a_dbg_quiet: assert property (p_dbg_quiet)
        else $error("debug side effect");
    property p_dbg_rsv;
        tk && req_debug_i && rsv && req_op_i != FPLG_OP_DEV_ERASE
            |=> dbg_ignored_o && !flash_cmd_valid_o;
    endproperty
    a_dbg_rsv: assert property (p_dbg_rsv)
        else $error("debug reserved kept");
    property p_fw_rsv;
        tk && !req_debug_i && rsv && req_op_i == FPLG_OP_READ
            |=> flash_error_reset_o;
    endproperty
    a_fw_rsv: assert property (p_fw_rsv)
        else $error("no reset on reserved");
    property p_dev;
        tk && req_debug_i && req_op_i == FPLG_OP_DEV_ERASE
            |=> flash_cmd_valid_o && flash_cmd_o == FPLG_OP_DEV_ERASE;
    endproperty
    a_dev: assert property (p_dev)
        else $error("no device erase");
    property p_wr;
        tk ##1 (flash_cmd_valid_o && flash_cmd_o == FPLG_OP_WRITE)
            |-> flash_addr_o == $past(req_addr_i)
            && flash_data_o == $past(req_data_i);
    endproperty
    a_wr: assert property (p_wr)
        else $error("write addr/data");
    property p_cause;
        !tk |=> !(flash_cmd_valid_o || xram_wr_o || dbg_ignored_o
            || flash_error_reset_o);
    endproperty
    a_cause: assert property (p_cause)
        else $error("pulse without request");
    // Busy blocks requests, so irqs stay held
    property p_busy;
        irq_hold_o |-> !req_ready_o;
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready while busy");
    property p_hold;
        flash_cmd_valid_o && flash_cmd_o != FPLG_OP_READ |=> irq_hold_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("irq not held");
endmodule : fplg_guard_properties

// *** tb/test_fplg_guard.sv ***
// Bench for the flash page lock guard
module test_fplg_guard;
    timeunit 1ns;
    timeprecision 1ps;
    import fplg_pkg::*;
    `define CHK(a, e) begin compares++; if ((a) !== (e)) begin \
        err_total++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
        $time, a, e); end end
    logic clk_i = 0, rstn_i = 0, por_rstn_i = 0; // Clock, resets
    logic psel = 0, penable = 0, pwrite = 0; // APB controls
    logic [APB_AW-1:0] paddr = '0; // APB address
    logic [31:0] pwdata = '0, prdata, r; // APB data, last read
    logic pready, pslverr; // APB answer
    logic rv = 0, rd = 0; // Request valid, debug
    fplg_op_t rop = FPLG_OP_READ, cmd; // Request, command kind
    logic [FA_W-1:0] ra = '0, rpc = '0, fa; // Addresses
    logic [7:0] rdt = '0, fd, lock; // Data bytes
    logic rdy, cv, xw, ign, fe, irq, done; // Outputs
    int err_total = 0, compares = 0; // Tallies
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    fplg_guard fplg_guard_i (.clk_i(clk_i), .rstn_i(rstn_i),
        .por_rstn_i(por_rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .req_valid_i(rv), .req_debug_i(rd), .req_op_i(rop),
        .req_addr_i(ra), .req_data_i(rdt), .pc_i(rpc),
        .req_ready_o(rdy), .lock_byte_i(lock), .flash_done_i(done),
        .flash_cmd_valid_o(cv), .flash_cmd_o(cmd), .flash_addr_o(fa),
        .flash_data_o(fd), .xram_wr_o(xw), .dbg_ignored_o(ign),
        .flash_error_reset_o(fe), .irq_hold_o(irq));
    fplg_flash_model fplg_flash_model_i (.clk_i(clk_i), .cmd_valid_i(cv),
        .cmd_i(cmd), .addr_i(fa), .data_i(fd), .lock_byte_o(lock),
        .done_o(done));
    // ==========
    // Tasks
    task automatic rst(input logic p); // Device reset, p: power-on
        @(posedge clk_i);
        rstn_i <= 0;
        por_rstn_i <= !p;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1;
        por_rstn_i <= 1;
        repeat (3) @(posedge clk_i);
    endtask : rst
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic err);
        @(posedge clk_i);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        r = prdata;
        `CHK(pslverr, err)
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0, 0);
        `CHK(r, e)
    endtask : rdchk
    // Monitor, keys, store control; no interrupts
    task automatic arm(input logic [31:0] mon, input logic [31:0] ps);
        apb(1, SRC_ADDR, mon, 0);
        apb(1, KEY_ADDR, {24'h0, KEY_CODE_FIRST}, 0);
        apb(1, KEY_ADDR, {24'h0, KEY_CODE_SECOND}, 0);
        apb(1, CTRL_ADDR, ps, 0);
    endtask : arm
    // Expected answer e: command, RAM write, ignored, error reset
    task automatic req(input logic d, input fplg_op_t o,
            input logic [13:0] a, input logic [7:0] v,
            input logic [13:0] pc, input logic [3:0] e);
        do begin
            @(posedge clk_i);
            #1;
        end while (rdy !== 1'b1);
        @(posedge clk_i);
        rv <= 1;
        rd <= d;
        rop <= o;
        ra <= a;
        rdt <= v;
        rpc <= pc;
        @(posedge clk_i);
        rv <= 0;
        #1 `CHK({cv, xw, ign, fe}, e)
    endtask : req
    task automatic end_of_test();
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // ==========
    // Sequence
    initial begin
        rst(1);
        rdchk(CTRL_ADDR, 32'h0);
        rdchk(STATUS_ADDR, 32'h0FF);
        apb(0, 12'h300, 0, 1);
        req(1, FPLG_OP_WRITE, LOCK_BYTE_ADDR, 8'hFD, 0, 4'h8);
        req(1, FPLG_OP_READ, 14'h0, 0, 0, 4'h8);
        rst(0);
        rdchk(STATUS_ADDR, 32'h1FD);
        req(1, FPLG_OP_READ, 14'h0, 0, 0, 4'h2);
        req(1, FPLG_OP_READ, 14'h0400, 0, 0, 4'h8);
        req(1, FPLG_OP_READ, LOCK_BYTE_ADDR, 0, 0, 4'h2);
        req(1, FPLG_OP_ERASE, 14'h3C00, 0, 0, 4'h2);
        req(1, FPLG_OP_WRITE, 14'h3E00, 0, 0, 4'h2);
        req(0, FPLG_OP_READ, 14'h0400, 0, 14'h0400, 4'h8);
        req(0, FPLG_OP_READ, LOCK_BYTE_ADDR, 0, 0, 4'h8);
        req(0, FPLG_OP_WRITE, 14'h10, 0, 0, 4'h4);
        req(0, FPLG_OP_READ, 14'h3FFF, 0, 0, 4'h1);
        req(0, FPLG_OP_READ, 14'h0, 0, 14'h0400, 4'h1);
        rst(0);
        apb(0, SRC_ADDR, 0, 0);
        `CHK(r[FERR_FLAG_BIT], 1'b1)
        arm(32'h83, 32'h1);
        req(0, FPLG_OP_WRITE, 14'h10, 8'h3C, 0, 4'h8);
        `CHK(cmd, FPLG_OP_WRITE)
        arm(32'h83, 32'h3);
        req(0, FPLG_OP_WRITE, 14'h0205, 8'h3C, 0, 4'h8);
        `CHK(cmd, FPLG_OP_ERASE)
        arm(32'h83, 32'h3);
        req(0, FPLG_OP_WRITE, 14'h3C00, 0, 0, 4'h1);
        rst(0);
        arm(32'h83, 32'h1);
        req(0, FPLG_OP_WRITE, LOCK_BYTE_ADDR, 8'hFC, 0, 4'h1);
        rst(0);
        arm(32'h02, 32'h1);
        req(0, FPLG_OP_WRITE, 14'h10, 0, 0, 4'h1);
        rst(0);
        apb(1, KEY_ADDR, 32'h12, 0);
        rdchk(KEY_ADDR, 32'h2);
        apb(1, SRC_ADDR, 32'h83, 0);
        apb(1, CTRL_ADDR, 32'h1, 0);
        req(0, FPLG_OP_WRITE, 14'h10, 0, 0, 4'h0);
        req(1, FPLG_OP_DEV_ERASE, 0, 0, 0, 4'h8);
        rst(0);
        rdchk(STATUS_ADDR, 32'h0FF);
        arm(32'h83, 32'h3);
        req(0, FPLG_OP_WRITE, 14'h3C00, 0, 0, 4'h1);
        end_of_test();
    end
    // A hang counts as a mismatch
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule : test_fplg_guard
bind fplg_guard fplg_guard_properties fplg_guard_properties_i (.*);
